// >>> sdace_pkg.sv
// Package with register map, field positions and types of the auto command error block
package sdace_pkg;
  // Register indices as printed, byte address is four times the index
  localparam logic [11:0] ACMD_ERR_IDX = 12'h03c;
  localparam logic [11:0] HOST_CTL2_IDX = 12'h03e;
  localparam logic [11:0] ERR_INT_STAT_IDX = 12'h080;
  localparam logic [11:0] ERR_STAT_EN_IDX = 12'h081;
  localparam logic [11:0] ERR_SIG_EN_IDX = 12'h082;
  localparam int unsigned BYTE_SHIFT = 2;
  // Auto command error status fields
  localparam int unsigned NOT_EXECUTE_BIT = 0;
  localparam int unsigned TIMEOUT_BIT = 1;
  localparam int unsigned CRC_BIT = 2;
  localparam int unsigned END_BIT_BIT = 3;
  localparam int unsigned INDEX_BIT = 4;
  localparam int unsigned NOT_ISSUED_BIT = 7;
  localparam logic [15:0] ACMD_ERR_RESET = 16'h0000;
  localparam logic [15:0] ACMD_ERR_IMPL_MASK = 16'h009f;
  // Host control 2 upper half
  localparam int unsigned PRESET_EN_BIT = 15;
  localparam int unsigned ASYNC_INT_BIT = 14;
  localparam logic HOST_CTL2_PRESET_RESET = 1'b0;
  // Error interrupt status summary position
  localparam int unsigned AUTO_CMD_SUM_BIT = 8;
  localparam logic [15:0] ERR_SUM_MASK = 16'h0100;
  // Response timeout in SDCLK cycles from the command end bit
  localparam int unsigned RESP_TIMEOUT_SDCLK = 64;
  localparam int unsigned TO_CNT_W = 7;
  localparam logic [TO_CNT_W-1:0] TO_CNT_ZERO = 7'h00;
  localparam logic [TO_CNT_W-1:0] TO_CNT_ONE = 7'h01;
  // Clock setting widths
  localparam int unsigned FREQ_SEL_W = 10;
  localparam int unsigned DRV_W = 2;

  // Result of checking one automatic command response
  typedef struct packed {
    logic index_bad;
    logic end_bit_bad;
    logic crc_bad;
  } sdace_resp_check_t;

  // Clock and driver settings handed to the clock and pad logic
  typedef struct packed {
    logic [FREQ_SEL_W-1:0] freq_sel;
    logic clk_gen_sel;
    logic [DRV_W-1:0] drv_strength;
  } sdace_clk_cfg_t;

  typedef enum logic [1:0] {
    SDACE_IDLE,
    SDACE_WAIT_RESP,
    SDACE_IN_RESP
  } sdace_state_t;
endpackage : sdace_pkg

// >>> sdace_top.sv
// Auto command error status and host control 2 upper half with APB access
// Notes on behaviour
// [R1] Status valid only while summary flag set
// [R2] Auto CMD23 error code kept in bits 4:1
// [R3] Bit 7: command not issued, CMD12 failed
// [R4] Bit 7 zero for CMD23 errors
// [R5] Bit 4: response index mismatch
// [R6] Bit 3: response end bit was zero
// [R7] Bit 2: response CRC check failed
// [R8] Bit 1: no response within 64 SDCLK
// [R9] Timeout set means ignore bits 4:2
// [R10] CRC plus timeout means line conflict
// [R11] Bit 0: CMD12 skipped after prior error
// [R12] Bit 0 zero otherwise or for CMD23
// [R13] Preset off: software programs clock settings
// [R14] Preset on: settings come from preset values
// [R15] Async interrupt enable reads zero, ignored
// [R16] Software preserves reserved bits on writes
// [R17] Summary at bit 8, gated by enables
`timescale 1ns/1ps
module sdace_top #(
  parameter int unsigned ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic acmd_sent,
  input wire logic acmd_is_cmd23,
  input wire logic sdclk_tick,
  input wire logic resp_start,
  input wire logic resp_done,
  input wire sdace_pkg::sdace_resp_check_t resp_check,
  input wire logic line_conflict,
  input wire logic acmd12_skipped,
  input wire logic pending_not_issued,
  input wire sdace_pkg::sdace_clk_cfg_t sw_clk_cfg,
  input wire sdace_pkg::sdace_clk_cfg_t preset_clk_cfg,
  output sdace_pkg::sdace_clk_cfg_t clk_cfg,
  output logic preset_en,
  output logic auto_cmd_err_status,
  output logic auto_cmd_err_signal
);
  localparam logic [ADDR_W-1:0] ACMD_ERR_ADDR =
    ADDR_W'(sdace_pkg::ACMD_ERR_IDX << sdace_pkg::BYTE_SHIFT);
  localparam logic [ADDR_W-1:0] HOST_CTL2_ADDR =
    ADDR_W'(sdace_pkg::HOST_CTL2_IDX << sdace_pkg::BYTE_SHIFT);
  localparam logic [ADDR_W-1:0] ERR_INT_STAT_ADDR =
    ADDR_W'(sdace_pkg::ERR_INT_STAT_IDX << sdace_pkg::BYTE_SHIFT);
  localparam logic [ADDR_W-1:0] ERR_STAT_EN_ADDR =
    ADDR_W'(sdace_pkg::ERR_STAT_EN_IDX << sdace_pkg::BYTE_SHIFT);
  localparam logic [ADDR_W-1:0] ERR_SIG_EN_ADDR =
    ADDR_W'(sdace_pkg::ERR_SIG_EN_IDX << sdace_pkg::BYTE_SHIFT);
  localparam logic [sdace_pkg::TO_CNT_W-1:0] TO_LIMIT =
    sdace_pkg::TO_CNT_W'(sdace_pkg::RESP_TIMEOUT_SDCLK);

  sdace_pkg::sdace_state_t state_reg;
  logic [sdace_pkg::TO_CNT_W-1:0] to_cnt_reg;
  logic cmd23_reg;
  logic [15:0] acmd_err_reg;
  logic [15:0] acmd_err_next;
  logic preset_en_reg;
  logic stat_en_reg;
  logic sig_en_reg;
  logic sum_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  sdace_pkg::sdace_clk_cfg_t clk_cfg_reg;
  logic sig_reg;

  logic access;
  logic wr_en;
  logic rd_en;
  logic mapped;
  logic timeout_hit;
  logic resp_err;
  logic err_event;
  logic [15:0] set_bits;
  logic [15:0] clr_bits;

  // APB decode
  assign access = psel & penable & ~pready_reg;
  assign wr_en = psel & penable & pready_reg & pwrite & ~pslverr_reg;
  assign rd_en = access & ~pwrite;
  always_comb begin
    case (paddr)
      ACMD_ERR_ADDR, HOST_CTL2_ADDR, ERR_INT_STAT_ADDR, ERR_STAT_EN_ADDR,
      ERR_SIG_EN_ADDR: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Response watch after the command end bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= sdace_pkg::SDACE_IDLE;
    end else begin
      case (state_reg)
        sdace_pkg::SDACE_IDLE: begin
          if (acmd_sent) begin
            state_reg <= sdace_pkg::SDACE_WAIT_RESP;
          end
        end
        sdace_pkg::SDACE_WAIT_RESP: begin
          if (resp_start) begin
            state_reg <= sdace_pkg::SDACE_IN_RESP;
          end else if (timeout_hit) begin
            state_reg <= sdace_pkg::SDACE_IDLE;
          end
        end
        sdace_pkg::SDACE_IN_RESP: begin
          if (resp_done) begin
            state_reg <= sdace_pkg::SDACE_IDLE;
          end
        end
        default: state_reg <= sdace_pkg::SDACE_IDLE;
      endcase
    end
  end

  // SDCLK count from the end bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      to_cnt_reg <= sdace_pkg::TO_CNT_ZERO;
    end else if (state_reg != sdace_pkg::SDACE_WAIT_RESP) begin
      to_cnt_reg <= sdace_pkg::TO_CNT_ZERO;
    end else if (sdclk_tick && !resp_start) begin
      to_cnt_reg <= to_cnt_reg + sdace_pkg::TO_CNT_ONE; // [R8]
    end
  end

  assign timeout_hit = (state_reg == sdace_pkg::SDACE_WAIT_RESP) && !resp_start &&
    sdclk_tick && (to_cnt_reg == TO_LIMIT - sdace_pkg::TO_CNT_ONE); // [R8]

  // Which automatic command is being watched
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd23_reg <= 1'b0;
    end else if (acmd_sent && state_reg == sdace_pkg::SDACE_IDLE) begin
      cmd23_reg <= acmd_is_cmd23;
    end
  end

  assign resp_err = (state_reg == sdace_pkg::SDACE_IN_RESP) && resp_done &&
    (resp_check.index_bad | resp_check.end_bit_bad | resp_check.crc_bad);

  // Bits raised by hardware this cycle
  always_comb begin
    set_bits = 16'h0000;
    if (resp_err) begin
      set_bits[sdace_pkg::INDEX_BIT] = resp_check.index_bad; // [R5] [R2]
      set_bits[sdace_pkg::END_BIT_BIT] = resp_check.end_bit_bad; // [R6] [R2]
      set_bits[sdace_pkg::CRC_BIT] = resp_check.crc_bad; // [R7] [R2]
    end
    if (timeout_hit) begin
      set_bits[sdace_pkg::TIMEOUT_BIT] = 1'b1; // [R8] [R9]
    end
    if (line_conflict) begin
      set_bits[sdace_pkg::CRC_BIT] = 1'b1; // [R10]
      set_bits[sdace_pkg::TIMEOUT_BIT] = 1'b1; // [R10]
    end
    if (acmd12_skipped) begin
      set_bits[sdace_pkg::NOT_EXECUTE_BIT] = 1'b1; // [R11]
    end
    if (pending_not_issued && !cmd23_reg) begin
      set_bits[sdace_pkg::NOT_ISSUED_BIT] = 1'b1; // [R3]
    end
  end

  assign err_event = |set_bits;

  // Software clears a bit by writing zero to it
  always_comb begin
    clr_bits = 16'h0000;
    if (wr_en && paddr == ACMD_ERR_ADDR) begin
      clr_bits = ~pwdata[15:0] & sdace_pkg::ACMD_ERR_IMPL_MASK;
    end
  end

  always_comb begin
    acmd_err_next = (acmd_err_reg & ~clr_bits) | set_bits;
    if (cmd23_reg && err_event) begin
      acmd_err_next[sdace_pkg::NOT_ISSUED_BIT] = 1'b0; // [R4]
      acmd_err_next[sdace_pkg::NOT_EXECUTE_BIT] = 1'b0; // [R12]
    end
    acmd_err_next = acmd_err_next & sdace_pkg::ACMD_ERR_IMPL_MASK;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acmd_err_reg <= sdace_pkg::ACMD_ERR_RESET;
    end else begin
      acmd_err_reg <= acmd_err_next;
    end
  end

  // Summary flag, set wins over write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sum_reg <= 1'b0;
    end else if (err_event && stat_en_reg) begin
      sum_reg <= 1'b1; // [R17] [R1]
    end else if (wr_en && paddr == ERR_INT_STAT_ADDR &&
                 pwdata[sdace_pkg::AUTO_CMD_SUM_BIT]) begin
      sum_reg <= 1'b0;
    end
  end

  // Summary enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_en_reg <= 1'b0;
      sig_en_reg <= 1'b0;
    end else if (wr_en) begin
      if (paddr == ERR_STAT_EN_ADDR) begin
        stat_en_reg <= pwdata[sdace_pkg::AUTO_CMD_SUM_BIT]; // [R17]
      end
      if (paddr == ERR_SIG_EN_ADDR) begin
        sig_en_reg <= pwdata[sdace_pkg::AUTO_CMD_SUM_BIT]; // [R17]
      end
    end
  end

  // Signal output follows the gated summary
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sig_reg <= 1'b0;
    end else begin
      sig_reg <= sum_reg & sig_en_reg; // [R17]
    end
  end

  // Host control 2 upper half, async enable not stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      preset_en_reg <= sdace_pkg::HOST_CTL2_PRESET_RESET;
    end else if (wr_en && paddr == HOST_CTL2_ADDR) begin
      preset_en_reg <= pwdata[sdace_pkg::PRESET_EN_BIT]; // [R15] [R16]
    end
  end

  // Effective clock and driver settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_cfg_reg <= '0;
    end else if (preset_en_reg) begin
      clk_cfg_reg <= preset_clk_cfg; // [R14]
    end else begin
      clk_cfg_reg <= sw_clk_cfg; // [R13]
    end
  end

  // APB answer one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= access;
      pslverr_reg <= access & ~mapped;
    end
  end

  // Read data stands only in the cycle with pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h00000000;
    end else if (rd_en) begin
      prdata_reg <= 32'h00000000;
      case (paddr)
        ACMD_ERR_ADDR: prdata_reg[15:0] <= acmd_err_reg; // [R1]
        HOST_CTL2_ADDR: begin
          prdata_reg[sdace_pkg::PRESET_EN_BIT] <= preset_en_reg;
          prdata_reg[sdace_pkg::ASYNC_INT_BIT] <= 1'b0; // [R15]
        end
        ERR_INT_STAT_ADDR: prdata_reg[sdace_pkg::AUTO_CMD_SUM_BIT] <= sum_reg;
        ERR_STAT_EN_ADDR: prdata_reg[sdace_pkg::AUTO_CMD_SUM_BIT] <= stat_en_reg;
        ERR_SIG_EN_ADDR: prdata_reg[sdace_pkg::AUTO_CMD_SUM_BIT] <= sig_en_reg;
        default: prdata_reg <= 32'h00000000;
      endcase
    end else begin
      prdata_reg <= 32'h00000000;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign clk_cfg = clk_cfg_reg;
  assign preset_en = preset_en_reg;
  assign auto_cmd_err_status = sum_reg;
  assign auto_cmd_err_signal = sig_reg;
endmodule : sdace_top

// >>> sdace_top_monitor.sv
// Checker for the bus handshake, preset selection and summary outputs
`timescale 1ns/1ps
module sdace_top_monitor #(
  parameter int unsigned ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire sdace_pkg::sdace_clk_cfg_t sw_clk_cfg,
  input wire sdace_pkg::sdace_clk_cfg_t preset_clk_cfg,
  input wire sdace_pkg::sdace_clk_cfg_t clk_cfg,
  input wire logic preset_en,
  input wire logic auto_cmd_err_status,
  input wire logic auto_cmd_err_signal
);
  logic [11:0] idx;
  logic mapped, acc, hc2;
  sdace_pkg::sdace_clk_cfg_t cfg_sel;
  assign idx = 12'(paddr >> sdace_pkg::BYTE_SHIFT);
  assign mapped = (paddr[1:0] == 2'h0) && (idx inside {sdace_pkg::ACMD_ERR_IDX,
    sdace_pkg::HOST_CTL2_IDX, sdace_pkg::ERR_INT_STAT_IDX, sdace_pkg::ERR_STAT_EN_IDX,
    sdace_pkg::ERR_SIG_EN_IDX});
  assign acc = psel && penable && pready;
  assign hc2 = mapped && (idx == sdace_pkg::HOST_CTL2_IDX);
  assign cfg_sel = preset_en ? preset_clk_cfg : sw_clk_cfg;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s; psel && !penable ##1 psel && penable; endsequence
  sequence answer_s; !pready ##1 pready; endsequence
  a_one_wait_state: assert property (setup_s |-> answer_s)
    else $error("pready not in second access cycle");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready longer than one cycle");
  a_error_on_unmapped: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr does not match the map");
  a_rdata_quiet: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
    else $error("prdata not zero outside a read");
  a_async_reads_zero: assert property (pready && !pwrite && hc2 |-> prdata[14:0] == 15'h0)
    else $error("host control 2 low bits not zero");
  a_preset_write: assert property (acc && pwrite && hc2 |=>
    preset_en == $past(pwdata[15])) else $error("preset enable write lost");
  a_cfg_select: assert property ($past(presetn) |-> clk_cfg == $past(cfg_sel))
    else $error("clock setting source wrong");
  a_signal_gated: assert property (auto_cmd_err_signal |-> $past(auto_cmd_err_status))
    else $error("signal without summary");
  a_summary_clear: assert property ($fell(auto_cmd_err_status) |-> $past(acc && pwrite))
    else $error("summary cleared without a write");
endmodule : sdace_top_monitor

bind sdace_top sdace_top_monitor #(.ADDR_W(ADDR_W)) sdace_top_monitor_i (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sw_clk_cfg,
  .preset_clk_cfg, .clk_cfg, .preset_en, .auto_cmd_err_status, .auto_cmd_err_signal);

// >>> sdace_card_model.sv
// Card side model of the command line events
`timescale 1ns/1ps
module sdace_card_model (
  input wire logic pclk,
  output logic acmd_sent,
  output logic acmd_is_cmd23,
  output logic sdclk_tick,
  output logic resp_start,
  output logic resp_done,
  output sdace_pkg::sdace_resp_check_t resp_check,
  output logic [2:0] evt
);
  initial begin
    {acmd_sent, acmd_is_cmd23, sdclk_tick, resp_start, resp_done} = 5'h00;
    resp_check = 3'h5;
    evt = 3'h0;
  end
  task automatic cmd(input logic c23);
    acmd_sent <= 1'b1;
    acmd_is_cmd23 <= c23;
    @(posedge pclk);
    acmd_sent <= 1'b0;
    @(posedge pclk);
  endtask : cmd
  // SDCLK only runs while a command is pending
  task automatic ticks(input int n);
    repeat (n) begin
      sdclk_tick <= 1'b1;
      @(posedge pclk);
      sdclk_tick <= 1'b0;
      @(posedge pclk);
    end
  endtask : ticks
  // Response checks valid only with the done pulse
  task automatic resp(input sdace_pkg::sdace_resp_check_t c);
    ticks(2);
    resp_start <= 1'b1;
    @(posedge pclk);
    resp_start <= 1'b0;
    ticks(4);
    resp_done <= 1'b1;
    resp_check <= c;
    @(posedge pclk);
    resp_done <= 1'b0;
    resp_check <= ~c;
    @(posedge pclk);
  endtask : resp
  // Conflict, skipped stop, pending not issued
  task automatic ev(input logic [2:0] k);
    evt <= k;
    @(posedge pclk);
    evt <= 3'h0;
    @(posedge pclk);
  endtask : ev
endmodule : sdace_card_model

// >>> sdace_top_tb.sv
// Register level testbench for the auto command error block
`timescale 1ns/1ps
module sdace_top_tb;
  localparam logic [11:0] A_ERR = 12'(sdace_pkg::ACMD_ERR_IDX << sdace_pkg::BYTE_SHIFT);
  localparam logic [11:0] A_HC2 = 12'(sdace_pkg::HOST_CTL2_IDX << sdace_pkg::BYTE_SHIFT);
  localparam logic [11:0] A_EIS = 12'(sdace_pkg::ERR_INT_STAT_IDX << sdace_pkg::BYTE_SHIFT);
  localparam logic [11:0] A_SEN = 12'(sdace_pkg::ERR_STAT_EN_IDX << sdace_pkg::BYTE_SHIFT);
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, preset_en;
  logic acmd_sent, acmd_is_cmd23, sdclk_tick, resp_start, resp_done;
  logic auto_cmd_err_status, auto_cmd_err_signal;
  logic [2:0] evt;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  sdace_pkg::sdace_resp_check_t resp_check;
  sdace_pkg::sdace_clk_cfg_t sw_clk_cfg, preset_clk_cfg, clk_cfg;
  int num_errors, compares;
  sdace_top sdace_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .acmd_sent, .acmd_is_cmd23, .sdclk_tick, .resp_start, .resp_done,
    .resp_check, .line_conflict(evt[2]), .acmd12_skipped(evt[1]), .pending_not_issued(evt[0]),
    .sw_clk_cfg, .preset_clk_cfg, .clk_cfg, .preset_en, .auto_cmd_err_status,
    .auto_cmd_err_signal);
  sdace_card_model sdace_card_model_i (.pclk, .acmd_sent, .acmd_is_cmd23, .sdclk_tick,
    .resp_start, .resp_done, .resp_check, .evt);
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, x, q);
  endtask : rd
  task automatic clr;
    apb(1'b1, A_ERR, 32'h0);
    apb(1'b1, A_EIS, 32'h100);
  endtask : clr
  task automatic close_out;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    close_out();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = 48'h0;
    sw_clk_cfg = 13'h1555;
    preset_clk_cfg = 13'h0aaa;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(A_ERR, 32'h0, "err_reset");
    rd(A_HC2, 32'h0, "hc2_reset");
    rd(12'h100, 32'h0, "bad_addr");
    chk("bad_err", 32'h1, 32'(e));
    apb(1'b1, A_SEN, 32'h100);
    apb(1'b1, A_SEN + 12'h4, 32'h100);
    for (int i = 0; i < 3; i++) begin
      sdace_card_model_i.cmd(1'b0);
      sdace_card_model_i.resp(3'(3'h4 >> i));
      repeat (3) @(posedge pclk);
      chk("signal", 32'h1, 32'(auto_cmd_err_signal));
      rd(A_ERR, 32'h10 >> i, "resp_err");
      clr();
      chk("cleared", 32'h0, 32'(auto_cmd_err_status));
    end
    sdace_card_model_i.cmd(1'b0);
    sdace_card_model_i.ticks(63);
    rd(A_ERR, 32'h0, "to_63");
    sdace_card_model_i.ticks(1);
    rd(A_ERR, 32'h2, "to_64");
    clr();
    apb(1'b1, A_SEN, 32'h0);
    sdace_card_model_i.ev(3'h4);
    repeat (3) @(posedge pclk);
    chk("masked", 32'h0, 32'(auto_cmd_err_status));
    apb(1'b1, A_ERR, 32'h9f);
    rd(A_ERR, 32'h6, "conflict");
    clr();
    sdace_card_model_i.cmd(1'b0);
    sdace_card_model_i.resp(3'h1);
    sdace_card_model_i.ev(3'h1);
    sdace_card_model_i.ev(3'h2);
    rd(A_ERR, 32'h85, "acmd12");
    clr();
    sdace_card_model_i.cmd(1'b1);
    sdace_card_model_i.resp(3'h2);
    sdace_card_model_i.ev(3'h1);
    sdace_card_model_i.ev(3'h2);
    rd(A_ERR, 32'h8, "acmd23");
    apb(1'b1, A_HC2, 32'hc000);
    rd(A_HC2, 32'h8000, "hc2");
    chk("cfg_preset", 32'(preset_clk_cfg), 32'(clk_cfg));
    preset_clk_cfg <= 13'h1234;
    sw_clk_cfg <= 13'h0f0f;
    repeat (2) @(posedge pclk);
    chk("cfg_preset2", 32'h00001234, 32'(clk_cfg));
    apb(1'b1, A_HC2, 32'h0);
    repeat (2) @(posedge pclk);
    chk("cfg_sw", 32'h00000f0f, 32'(clk_cfg));
    sw_clk_cfg <= 13'h10f0;
    preset_clk_cfg <= 13'h0aaa;
    repeat (2) @(posedge pclk);
    chk("cfg_sw2", 32'h000010f0, 32'(clk_cfg));
    apb(1'b1, A_HC2, 32'h8000);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(A_HC2, 32'h0, "hc2_rst2");
    rd(A_ERR, 32'h0, "err_rst2");
    close_out();
  end
endmodule : sdace_top_tb
